// ### hw/sdac_pkg.sv
// Shared constants for the serial converter control port
package sdac_pkg;
    localparam int WORD_BITS = 10;
    localparam int DATA_BITS = 8;
    localparam int SEL_MSB = 9;
    localparam int SEL_LSB = 8;
    localparam int OFFSET_SRC_BIT = 5;
    localparam int OFFSET_DIR_BIT = 4;
    localparam int OFFSET_MAG_BITS = 4;
    // Target selector codes
    localparam logic [1:0] SEL_OFFSET_A = 2'h0;
    localparam logic [1:0] SEL_SDAC1 = 2'h1;
    localparam logic [1:0] SEL_SDAC0 = 2'h2;
    localparam logic [1:0] SEL_OFFSET_B = 2'h3;
    // Reset values
    localparam logic [7:0] DAC_RESET = 8'h00;
    localparam logic [9:0] SHIFT_RESET = 10'h000;
    // Serial clock nominal rate and host divider
    localparam int SERIAL_CLK_KHZ = 256;
    localparam int SYS_CLK_KHZ = 20000;
    localparam int HALF_PERIOD_CYCLES = SYS_CLK_KHZ / (2 * SERIAL_CLK_KHZ);
    // Settling wait after wake, in microseconds
    localparam int SETTLE_US = 100;
    localparam int SYS_CLK_MHZ = 20;
    localparam int SETTLE_CYCLES = SETTLE_US * SYS_CLK_MHZ;
endpackage : sdac_pkg

// ### hw/sdac_link_if.sv
// Link between host and converter control port
`timescale 1ns/100ps
interface sdac_link_if;
    logic serial_clk;
    logic serial_data_in;
    logic load_strobe;
    logic adc_sleep_n;
    logic parallel_dac_sleep_n;
    logic serial_dac_sleep_n;
    modport host (
        output serial_clk, serial_data_in, load_strobe,
        output adc_sleep_n, parallel_dac_sleep_n, serial_dac_sleep_n
    );
    modport device (
        input serial_clk, serial_data_in, load_strobe,
        input adc_sleep_n, parallel_dac_sleep_n, serial_dac_sleep_n
    );
endinterface : sdac_link_if

// ### hw/sdac_shift_reg.sv
// Serial input shift register clocked by the link clock
`timescale 1ns/100ps
module sdac_shift_reg #(
    parameter int WIDTH = 10
) (
    // Link clock and data
    input wire logic serial_clk,
    input wire logic serial_data_in,
    // Held word
    output logic [WIDTH-1:0] word_q
);
    // Shifts on every rising edge, MSB first; surplus pulses push bits out
    always_ff @(posedge serial_clk) begin
        word_q <= {word_q[WIDTH-2:0], serial_data_in};
    end
endmodule : sdac_shift_reg

// ### hw/sdac_device.sv
// Converter control port: shift register, load decode, sleep gating
`timescale 1ns/100ps
// Behaviour
// - Ten-bit word: two selector, eight data
// - Selector codes choose one of four targets
// - Host gives exactly ten clock pulses
// - Register shifts on every pulse
// - Clock and data idle low
// - Data sampled on serial clock rise
// - Most significant bit sent first
// - Strobe fall loads data into target
// - Serial DAC holds until next strobe fall
// - Strobe idles low, pulsed after shift
// - Serial DAC codes straight binary
// - ADC sleeps while its input low
// - Parallel DAC sleep grounds outputs, references
// - Serial DAC sleep input low sleeps both
// - Host waits settling time after wake; the host only flags settled, req_ready ignores it
// - Serial clock nominally 256 kHz
// - Offset bit D5 picks factory or user
// - Offset bit D4 picks decrease or increase
// - Four low bits are offset magnitude
module sdac_device (
    // Link side
    sdac_link_if.device link,
    // Serial DAC codes
    output logic [7:0] serial_dac0_out,
    output logic [7:0] serial_dac1_out,
    // Offset registers of the parallel DACs
    output logic offset_a_user,
    output logic offset_a_incr,
    output logic [3:0] offset_a_mag,
    output logic offset_b_user,
    output logic offset_b_incr,
    output logic [3:0] offset_b_mag,
    // Power state of each section
    output logic adc_enable,
    output logic parallel_dac_enable,
    output logic buffered_ref_enable,
    output logic serial_dac_enable
);
    logic [9:0] word;
    logic [1:0] sel;
    logic [7:0] data;
    logic [7:0] dac0_q;
    logic [7:0] dac1_q;
    logic [5:0] off_a_q;
    logic [5:0] off_b_q;

    sdac_shift_reg #(
        .WIDTH(sdac_pkg::WORD_BITS)
    ) u_shift (
        .serial_clk(link.serial_clk),
        .serial_data_in(link.serial_data_in),
        .word_q(word)
    );

    // Split the held word into selector and data
    assign sel = word[sdac_pkg::SEL_MSB:sdac_pkg::SEL_LSB];
    assign data = word[sdac_pkg::DATA_BITS-1:0];

    // Load on the strobe's falling edge; there is no reset pin, so
    // targets hold whatever they power up with until the first load
    always_ff @(negedge link.load_strobe) begin
        if (sel == sdac_pkg::SEL_SDAC0) begin
            dac0_q <= data;
        end
    end

    always_ff @(negedge link.load_strobe) begin
        if (sel == sdac_pkg::SEL_SDAC1) begin
            dac1_q <= data;
        end
    end

    // Offset registers keep source, direction and magnitude
    always_ff @(negedge link.load_strobe) begin
        if (sel == sdac_pkg::SEL_OFFSET_A) begin
            off_a_q <= data[5:0];
        end
    end

    always_ff @(negedge link.load_strobe) begin
        if (sel == sdac_pkg::SEL_OFFSET_B) begin
            off_b_q <= data[5:0];
        end
    end

    // Straight binary codes passed to the converters
    assign serial_dac0_out = dac0_q;
    assign serial_dac1_out = dac1_q;

    // Offset fields; direction and magnitude matter only in user mode
    assign offset_a_user = off_a_q[sdac_pkg::OFFSET_SRC_BIT];
    assign offset_a_incr = off_a_q[sdac_pkg::OFFSET_DIR_BIT];
    assign offset_a_mag = off_a_q[sdac_pkg::OFFSET_MAG_BITS-1:0];
    assign offset_b_user = off_b_q[sdac_pkg::OFFSET_SRC_BIT];
    assign offset_b_incr = off_b_q[sdac_pkg::OFFSET_DIR_BIT];
    assign offset_b_mag = off_b_q[sdac_pkg::OFFSET_MAG_BITS-1:0];

    // Sleep pins act directly; analog power has no clock to wait on
    assign adc_enable = link.adc_sleep_n;
    assign parallel_dac_enable = link.parallel_dac_sleep_n;
    assign buffered_ref_enable = link.parallel_dac_sleep_n;
    assign serial_dac_enable = link.serial_dac_sleep_n;
endmodule : sdac_device

// ### hw/sdac_host.sv
// Host end: shifts a word out on a gated clock, then pulses the strobe
`timescale 1ns/100ps
module sdac_host (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Write request
    input wire logic req_valid,
    input wire logic [1:0] req_sel,
    input wire logic [7:0] req_data,
    output logic req_ready,
    // Sleep requests, high to sleep
    input wire logic adc_sleep,
    input wire logic parallel_dac_sleep,
    input wire logic serial_dac_sleep,
    // Settling done after the last wake
    output logic settled,
    // Link side
    sdac_link_if.host link
);
    typedef enum logic [3:0] {
        IDLE = 4'h1,
        LOW = 4'h2,
        HIGH = 4'h4,
        STROBE = 4'h8
    } state_type;

    state_type state_q;
    logic [9:0] word_q;
    logic [3:0] bits_q;
    logic [7:0] div_q;
    logic div_done;
    logic sclk_q;
    logic serial_data_in_q;
    logic strobe_q;
    logic [2:0] sleep_q;
    logic [15:0] settle_q;

    assign div_done = (div_q == 8'(sdac_pkg::HALF_PERIOD_CYCLES - 1));
    assign req_ready = (state_q == IDLE);

    // Half-period divider sets the serial clock rate
    always_ff @(posedge clk_sys) begin
        if (rst || state_q == IDLE || div_done) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Transfer sequence: ten pulses, then one strobe pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= IDLE;
            word_q <= sdac_pkg::SHIFT_RESET;
            bits_q <= 4'h0;
            sclk_q <= 1'b0;
            serial_data_in_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    sclk_q <= 1'b0;
                    serial_data_in_q <= 1'b0;
                    strobe_q <= 1'b0;
                    if (req_valid) begin
                        word_q <= {req_sel, req_data};
                        bits_q <= 4'h0;
                        state_q <= LOW;
                    end
                end
                LOW: begin
                    // Data set up half a period ahead of the rise
                    serial_data_in_q <= word_q[9];
                    if (div_done) begin
                        sclk_q <= 1'b1;
                        state_q <= HIGH;
                    end
                end
                HIGH: begin
                    if (div_done) begin
                        sclk_q <= 1'b0;
                        word_q <= {word_q[8:0], 1'b0};
                        bits_q <= bits_q + 4'h1;
                        if (bits_q == 4'(sdac_pkg::WORD_BITS - 1)) begin
                            serial_data_in_q <= 1'b0;
                            state_q <= STROBE;
                        end else begin
                            state_q <= LOW;
                        end
                    end
                end
                STROBE: begin
                    // High for one half period less one cycle after shifting ends
                    strobe_q <= 1'b1;
                    if (div_done) begin
                        strobe_q <= 1'b0;
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end

    // Sleep pins and settling count after any wake
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_q <= 3'h0;
            settle_q <= 16'h0000;
        end else begin
            sleep_q <= {adc_sleep, parallel_dac_sleep, serial_dac_sleep};
            if ((sleep_q & ~{adc_sleep, parallel_dac_sleep, serial_dac_sleep}) != 3'h0) begin
                settle_q <= 16'(sdac_pkg::SETTLE_CYCLES);
            end else if (settle_q != 16'h0000) begin
                settle_q <= settle_q - 16'h0001;
            end
        end
    end

    assign settled = (settle_q == 16'h0000);
    assign link.serial_clk = sclk_q;
    assign link.serial_data_in = serial_data_in_q;
    assign link.load_strobe = strobe_q;
    assign link.adc_sleep_n = ~sleep_q[2];
    assign link.parallel_dac_sleep_n = ~sleep_q[1];
    assign link.serial_dac_sleep_n = ~sleep_q[0];
endmodule : sdac_host

// ### verification/sdac_monitor.sv
// Concurrent checks on the host-to-device link
`timescale 1ns/100ps
module sdac_monitor (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link signals
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic load_strobe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] hi_q;
    logic [7:0] st_q;
    logic [4:0] pulses_q;
    logic clk_prev_q;
    logic stb_prev_q;
    // High-phase run lengths, zero while low
    always_ff @(posedge clk_sys) begin
        hi_q <= (serial_clk && !rst) ? hi_q + 8'h01 : 8'h00;
        st_q <= (load_strobe && !rst) ? st_q + 8'h01 : 8'h00;
    end
    // Clock rises since the last load; a strobe fall starts a new word
    always_ff @(posedge clk_sys) begin
        clk_prev_q <= serial_clk;
        stb_prev_q <= load_strobe;
        if (rst || (stb_prev_q && !load_strobe)) begin
            pulses_q <= 5'h00;
        end else if (serial_clk && !clk_prev_q) begin
            pulses_q <= pulses_q + 5'h01;
        end
    end
    sclk_high_a: assert property ($fell(serial_clk) |-> hi_q == 8'h27)
        else $error("serial clock high phase not 39 cycles");
    // The host raises the strobe one cycle into its last half period, so it stands 38 cycles
    strobe_width_a: assert property ($fell(load_strobe) |-> st_q == 8'h26)
        else $error("strobe width not 38 cycles");
    pulse_count_a: assert property ($rose(load_strobe) |-> pulses_q == 5'h0A)
        else $error("strobe not after exactly ten pulses");
    idle_low_a: assert property ($fell(load_strobe) |-> !serial_clk && !serial_data_in)
        else $error("link not idle low after load");
    data_stable_a: assert property (serial_clk |-> $stable(serial_data_in))
        else $error("data moved while serial clock high");
    reset_idle_a: assert property ($fell(rst) |-> !serial_clk && !load_strobe)
        else $error("link not idle after reset");
    strobe_quiet_a: assert property (load_strobe |-> !serial_clk)
        else $error("serial clock pulsed during strobe");
    strobe_follows_a: assert property (
        $fell(serial_clk) && pulses_q == 5'h0A |-> ##[0:40] load_strobe)
        else $error("no strobe after tenth pulse");
endmodule : sdac_monitor

// ### verification/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_sel = 2'h0;
    logic [7:0] req_data = 8'h00;
    logic [2:0] sleep_req = 3'h0;
    logic req_ready;
    logic settled;
    logic [7:0] dac0_out;
    logic [7:0] dac1_out;
    // Nets, since each is driven in pieces by several ports
    wire [5:0] off_a;
    wire [5:0] off_b;
    wire [3:0] enables;
    logic [7:0] exp0;
    logic [7:0] exp1;
    logic [5:0] exp_a;
    logic [5:0] exp_b;
    int n_errors = 0;
    int check_count = 0;
    sdac_link_if link ();
    // Both ends face each other across the link
    sdac_host sdac_host_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req_sel(req_sel), .req_data(req_data), .req_ready(req_ready),
        .adc_sleep(sleep_req[0]), .parallel_dac_sleep(sleep_req[1]),
        .serial_dac_sleep(sleep_req[2]), .settled(settled), .link(link));
    sdac_device sdac_device_inst (.link(link), .serial_dac0_out(dac0_out),
        .serial_dac1_out(dac1_out), .offset_a_user(off_a[5]), .offset_a_incr(off_a[4]),
        .offset_a_mag(off_a[3:0]), .offset_b_user(off_b[5]), .offset_b_incr(off_b[4]),
        .offset_b_mag(off_b[3:0]), .adc_enable(enables[3]),
        .parallel_dac_enable(enables[2]), .buffered_ref_enable(enables[1]),
        .serial_dac_enable(enables[0]));
    sdac_monitor sdac_monitor_inst (.clk_sys(clk_sys), .rst(rst), .serial_clk(link.serial_clk),
        .serial_data_in(link.serial_data_in), .load_strobe(link.load_strobe));
    // System clock, 50 ns period
    always #25 clk_sys = ~clk_sys;
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: %s saw %h want %h", $time, what, seen, want);
        end
    endtask : check
    // One word through the host; waits are bounded so a stuck host shows up
    task automatic send(input logic [1:0] sel, input logic [7:0] data);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (req_ready !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        req_valid <= 1'b1;
        req_sel <= sel;
        req_data <= data;
        @(negedge clk_sys);
        req_valid <= 1'b0;
        while (req_ready !== 1'b1 && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        check({7'h00, req_ready}, 8'h01, "ready");
        case (sel)
            sdac_pkg::SEL_SDAC0: exp0 = data;
            sdac_pkg::SEL_SDAC1: exp1 = data;
            sdac_pkg::SEL_OFFSET_A: exp_a = data[5:0];
            default: exp_b = data[5:0];
        endcase
    endtask : send
    task automatic check_all;
        check(dac0_out, exp0, "dac0");
        check(dac1_out, exp1, "dac1");
        check({2'h0, off_a}, {2'h0, exp_a}, "offset a");
        check({2'h0, off_b}, {2'h0, exp_b}, "offset b");
    endtask : check_all
    // Every selector code, then two rewrites that must leave the rest alone
    task automatic targets_task;
        logic [7:0] vals [4];
        vals = '{8'h2B, 8'h81, 8'h4E, 8'h1D};
        for (int i = 0; i < 4; i++) begin
            send(i[1:0], vals[i]);
        end
        check_all();
        send(sdac_pkg::SEL_SDAC0, 8'hB3);
        check_all();
        send(sdac_pkg::SEL_OFFSET_B, 8'h30);
        check_all();
    endtask : targets_task
    // End codes sent back to back
    task automatic codes_task;
        send(sdac_pkg::SEL_SDAC0, 8'h00);
        send(sdac_pkg::SEL_SDAC1, 8'hFF);
        check_all();
    endtask : codes_task
    // Each sleep line alone, then wake and settling
    task automatic sleep_task;
        for (int i = 0; i < 3; i++) begin
            sleep_req <= 3'h1 << i;
            repeat (3) @(negedge clk_sys);
            check({4'h0, enables}, {4'h0, ~(i == 0), ~(i == 1), ~(i == 1), ~(i == 2)},
                "enables");
        end
        sleep_req <= 3'h0;
        repeat (3) @(negedge clk_sys);
        check({4'h0, enables}, 8'h0F, "awake");
        check({7'h00, settled}, 8'h00, "settling");
        repeat (sdac_pkg::SETTLE_CYCLES) @(negedge clk_sys);
        check({7'h00, settled}, 8'h01, "settled");
    endtask : sleep_task
    task automatic tally_and_finish;
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog, well beyond the roughly 8600 cycles the tests take
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rst <= 1'b0;
        targets_task();
        codes_task();
        sleep_task();
        tally_and_finish();
    end
endmodule : testbench
